// ===== hdl/slem_params.svh
// Purpose: Offsets, field positions, reset values for the link error monitor
// Assumes: Byte-wide register port with 12-bit byte addresses
// Notes: Definitions only
`ifndef SLEM_PARAMS_SVH
`define SLEM_PARAMS_SVH
`define SLEM_ADDR_W 12
`define SLEM_OFS_CTRL 12'h477
`define SLEM_OFS_ILAS_MF 12'h478
`define SLEM_OFS_ERR_THRES 12'h47C
`define SLEM_OFS_SYNC_MASK 12'h47D
`define SLEM_OFS_LANE0_CTRL 12'h480
`define SLEM_OFS_STATUS 12'h4F0
`define SLEM_OFS_CNT_BASE 12'h4F4
`define SLEM_BIT_AUTO_CLR 3
`define SLEM_RST_ILAS_MF 8'h01
`define SLEM_RST_ERR_THRES 8'hFF
`define SLEM_RST_SYNC_MASK 3'h7
`define SLEM_RST_ENA 3'h7
`define SLEM_RST_CLR 3'h7
`define SLEM_ENA_LSB 3
`endif

// ===== hdl/slem_pkg.sv
// Purpose: Types for the link error monitor
// Assumes: Three error kinds per lane
// Notes: Index 0 disparity, 1 not-in-table, 2 unexpected control
package slem_pkg;
  typedef struct packed {
    logic unexpected_control_char_error;
    logic not_in_table_error;
    logic bad_disparity_error;
  } slem_err_t;
  typedef struct packed {
    logic wr;
    logic [11:0] addr;
    logic [7:0] wdata;
  } slem_req_t;
endpackage

// ===== hdl/slem_monitor.sv
// Purpose: Per-lane 8b/10b error counting, threshold compare, sync request
// Assumes: Errors arrive as one-cycle pulses on sys_clk from the lane decoder
// Notes: Register port is byte wide, write applies in one cycle, read data registered
//
// Overview of operation
// - Auto-clear resets only the tripping counter
// - Multiframe count setting; valid 1, 2, 4
// - Count three error kinds, compare shared threshold
// - Threshold equal raises interrupt or sync per masks
// - Sync asserted when masked counter reached threshold
// - Sync mask bit2 disparity, bit0 unexpected control
// - Lane 0 enables: bit2 unexpected, bit0 disparity
// - Per lane clear field, bits 2,1,0
`timescale 1ns/1ns
`include "slem_params.svh"
module slem_monitor #(
  parameter int LANES = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Register port
  input wire slem_pkg::slem_req_t reg_req,
  output logic [7:0] reg_rdata,
  // Lane decoder
  input wire logic lane_decoder_soft_reset,
  input wire slem_pkg::slem_err_t [LANES-1:0] lane_err,
  // Status outputs
  output logic [7:0] ilas_multiframe_count,
  output logic ilas_mf_valid,
  output logic sync_request_output,
  output logic irq_request
);
  import slem_pkg::*;

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic auto_clear_tripping_counter_q;
  logic [7:0] ilas_mf_q;
  logic [7:0] error_threshold_q;
  logic [2:0] sync_mask_q;
  logic [2:0] irq_mask_q;
  logic [LANES-1:0][2:0] ena_q;
  logic [LANES-1:0][2:0] clr_q;
  logic [LANES-1:0][2:0][7:0] cnt_q;
  logic [LANES-1:0][2:0] hit;
  logic [LANES-1:0][2:0] trip;

  // Lane control registers sit at consecutive offsets from lane 0
  function automatic logic is_lane_ctrl(input logic [11:0] a, input int l);
    return a == 12'(`SLEM_OFS_LANE0_CTRL + l);
  endfunction

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      auto_clear_tripping_counter_q <= 1'b0;
      ilas_mf_q <= `SLEM_RST_ILAS_MF;
      error_threshold_q <= `SLEM_RST_ERR_THRES;
      sync_mask_q <= `SLEM_RST_SYNC_MASK;
      irq_mask_q <= 3'h0;
    end else if (reg_req.wr) begin
      if (reg_req.addr == `SLEM_OFS_CTRL) begin
        auto_clear_tripping_counter_q <= reg_req.wdata[`SLEM_BIT_AUTO_CLR];
      end
      if (reg_req.addr == `SLEM_OFS_ILAS_MF) begin
        ilas_mf_q <= reg_req.wdata;
      end
      if (reg_req.addr == `SLEM_OFS_ERR_THRES) begin
        error_threshold_q <= reg_req.wdata;
      end
      if (reg_req.addr == `SLEM_OFS_SYNC_MASK) begin
        sync_mask_q <= reg_req.wdata[2:0];
        irq_mask_q <= reg_req.wdata[6:4];
      end
    end
  end

  assign ilas_multiframe_count = ilas_mf_q;
  // Only 1, 2 and 4 are valid multiframe counts
  assign ilas_mf_valid = (ilas_mf_q == 8'h01) || (ilas_mf_q == 8'h02)
                         || (ilas_mf_q == 8'h04);

  // ----------------------------------------
  // Per lane counters
  // ----------------------------------------
  genvar gl, gk;
  generate
    for (gl = 0; gl < LANES; gl++) begin : g_lane
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          ena_q[gl] <= `SLEM_RST_ENA;
          clr_q[gl] <= `SLEM_RST_CLR;
        end else if (reg_req.wr && is_lane_ctrl(reg_req.addr, gl)) begin
          ena_q[gl] <= reg_req.wdata[`SLEM_ENA_LSB+:3];
          clr_q[gl] <= reg_req.wdata[2:0];
        end
      end
      for (gk = 0; gk < 3; gk++) begin : g_kind
        // Sync mask bit order is reversed against enables and counters
        assign hit[gl][gk] = cnt_q[gl][gk] == error_threshold_q;
        assign trip[gl][gk] = hit[gl][gk] && sync_mask_q[2-gk];
        always_ff @(posedge sys_clk or negedge arst_n) begin
          if (!arst_n) begin
            cnt_q[gl][gk] <= 8'h00;
          end else if (clr_q[gl][gk]) begin
            cnt_q[gl][gk] <= 8'h00;
          end else if (auto_clear_tripping_counter_q && trip[gl][gk]) begin
            cnt_q[gl][gk] <= 8'h00;
          end else if (ena_q[gl][gk] && lane_err[gl][gk] && !hit[gl][gk]
                       && !lane_decoder_soft_reset) begin
            cnt_q[gl][gk] <= cnt_q[gl][gk] + 8'h01;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Sync and interrupt requests
  // ----------------------------------------
  // Interrupt masks follow the same reversed order as the sync masks
  always_comb begin
    sync_request_output = 1'b0;
    irq_request = 1'b0;
    for (int l = 0; l < LANES; l++) begin
      for (int k = 0; k < 3; k++) begin
        sync_request_output |= trip[l][k];
        irq_request |= hit[l][k] && irq_mask_q[2-k];
      end
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Counters read back at base plus four per lane plus kind
  logic [7:0] rd_d;
  always_comb begin
    rd_d = 8'h00;
    case (reg_req.addr)
      `SLEM_OFS_CTRL: rd_d = {4'h0, auto_clear_tripping_counter_q, 3'h0};
      `SLEM_OFS_ILAS_MF: rd_d = ilas_mf_q;
      `SLEM_OFS_ERR_THRES: rd_d = error_threshold_q;
      `SLEM_OFS_SYNC_MASK: rd_d = {1'b0, irq_mask_q, 1'b0, sync_mask_q};
      `SLEM_OFS_STATUS: rd_d = {5'h00, ilas_mf_valid, irq_request, sync_request_output};
      default: rd_d = 8'h00;
    endcase
    for (int l = 0; l < LANES; l++) begin
      if (is_lane_ctrl(reg_req.addr, l)) begin
        rd_d = {2'h0, ena_q[l], clr_q[l]};
      end
      for (int k = 0; k < 3; k++) begin
        if (reg_req.addr == 12'(`SLEM_OFS_CNT_BASE + 4 * l + k)) begin
          rd_d = cnt_q[l][k];
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rd_d;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sync_on_trip_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (cnt_q[0][0] == error_threshold_q && sync_mask_q[2]) |-> sync_request_output)
    else $error("sync not raised on lane 0 disparity trip");
  sync_nit_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (cnt_q[0][1] == error_threshold_q && sync_mask_q[1]) |-> sync_request_output)
    else $error("sync not raised on lane 0 not-in-table trip");
  auto_clear_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (auto_clear_tripping_counter_q && trip[0][1] && !clr_q[0][1]) |=> cnt_q[0][1] == 8'h00)
    else $error("tripping counter not auto cleared");
  other_kept_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (trip[0][1] && !trip[0][0] && !clr_q[0][0] && !lane_err[0][0] && !reg_req.wr)
    |=> $stable(cnt_q[0][0]))
    else $error("other counter disturbed");
  mask_order_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (hit[0][2] && !sync_mask_q[0]) |-> !trip[0][2])
    else $error("unexpected control trip ignores mask bit 0");
  disabled_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (!ena_q[0][0] && !clr_q[0][0] && !trip[0][0]) |=> $stable(cnt_q[0][0]))
    else $error("disabled counter changed");
  count_step_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (ena_q[0][1] && lane_err[0][1] && !hit[0][1] && !clr_q[0][1]
     && !lane_decoder_soft_reset) |=> cnt_q[0][1] == $past(cnt_q[0][1]) + 8'h01)
    else $error("error not counted");
  clear_field_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clr_q[0][2] |=> cnt_q[0][2] == 8'h00)
    else $error("clear field did not zero counter");
  irq_gate_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (hit[0][1] && irq_mask_q[1]) |-> irq_request)
    else $error("interrupt not raised");
  mf_valid_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (ilas_mf_q == 8'h03) |-> !ilas_mf_valid)
    else $error("invalid multiframe count accepted");

  // ----------------------------------------
  // Checks on saturation, soft reset, masks and multiframe count
  // ----------------------------------------
  saturate_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (hit[0][2] && !clr_q[0][2] && !(auto_clear_tripping_counter_q && trip[0][2]))
    |=> $stable(cnt_q[0][2]))
    else $error("counter moved past the threshold");
  soft_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (lane_decoder_soft_reset && !clr_q[0][1]
     && !(auto_clear_tripping_counter_q && trip[0][1])) |=> $stable(cnt_q[0][1]))
    else $error("counter moved while decoder held in soft reset");
  irq_off_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (irq_mask_q == 3'h0) |-> !irq_request)
    else $error("interrupt raised with all masks clear");
  mf_four_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (ilas_mf_q == 8'h04) |-> ilas_mf_valid)
    else $error("valid multiframe count rejected");
endmodule

// ===== sim/slem_err_src.sv
// Purpose: Lane decoder error source standing in for the far-side framer
// Assumes: One-cycle error pulses on sys_clk
// Notes: Lines idle low between pulses
`timescale 1ns/1ns
module slem_err_src #(
  parameter int LANES = 4
) (
  // Clock
  input wire logic sys_clk,
  // Error pulses
  output slem_pkg::slem_err_t [LANES-1:0] lane_err
);
  import slem_pkg::*;
  initial lane_err = '0;
  // One pulse, then gap idle edges so the lane can be quick or slow
  task automatic pulse(input int ln, input int k, input int gap);
    @(posedge sys_clk) lane_err[ln][k] <= 1'b1;
    @(posedge sys_clk) lane_err[ln][k] <= 1'b0;
    repeat (gap) @(posedge sys_clk);
  endtask
endmodule

// ===== sim/tb.sv
// Purpose: Self-checking bench for the link error monitor
// Assumes: Byte register port, threshold 3 in the tests
// Notes: Counter readback at 0x4F4 + 4*lane + kind
`timescale 1ns/1ns
module tb;
  import slem_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic sr = 1'b1;
  slem_req_t req = '0;
  slem_err_t [3:0] lane_err;
  logic [7:0] rdata, mfc;
  logic mfv, sync_o, irq_o;
  int bad_count = 0;
  int cmp_count = 0;
  always #5 sys_clk = ~sys_clk;
  slem_err_src #(.LANES(4)) src (.sys_clk(sys_clk), .lane_err(lane_err));
  slem_monitor #(.LANES(4)) uut (.sys_clk(sys_clk), .arst_n(arst_n), .reg_req(req),
    .reg_rdata(rdata), .lane_decoder_soft_reset(sr), .lane_err(lane_err),
    .ilas_multiframe_count(mfc), .ilas_mf_valid(mfv), .sync_request_output(sync_o),
    .irq_request(irq_o));
  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk) req <= '{1'b1, a, d};
    @(posedge sys_clk) req.wr <= 1'b0;
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [7:0] e);
    @(posedge sys_clk) req.addr <= a;
    @(posedge sys_clk);
    #1 chk(nm, e, rdata);
  endtask
  task automatic cnt(input int ln, input int k, input logic [7:0] e);
    rd("counter", 12'h4F4 + 12'(4 * ln + k), e);
  endtask
  task automatic errs(input int k, input int n);
    repeat (n) src.pulse(0, k, 1);
    @(posedge sys_clk);
    #1;
  endtask
  task automatic wrap_up;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    wrap_up();
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd("ilas_mf", 12'h478, 8'h01);
    rd("thres", 12'h47C, 8'hFF);
    rd("sync_mask", 12'h47D, 8'h07);
    rd("lane0_ctrl", 12'h480, 8'h3F);
    rd("unmapped", 12'h400, 8'h00);
    for (int v = 1; v <= 4; v++) begin
      wr(12'h478, 8'(v));
      rd("ilas_mf", 12'h478, 8'(v));
      chk("mf_valid", {7'h00, v != 3}, {7'h00, mfv});
      chk("mf_count", 8'(v), mfc);
    end
    wr(12'h47C, 8'h03);
    wr(12'h47D, 8'h14);
    wr(12'h480, 8'h38);
    @(posedge sys_clk) sr <= 1'b0;
    errs(0, 2);
    chk("flags", 8'h00, {6'h00, irq_o, sync_o});
    errs(2, 3);
    chk("flags", 8'h02, {6'h00, irq_o, sync_o});
    errs(0, 1);
    chk("flags", 8'h03, {6'h00, irq_o, sync_o});
    rd("status", 12'h4F0, 8'h07);
    errs(2, 1);
    cnt(0, 2, 8'h03);
    cnt(0, 0, 8'h03);
    cnt(0, 1, 8'h00);
    @(posedge sys_clk) sr <= 1'b1;
    errs(1, 1);
    cnt(0, 1, 8'h00);
    wr(12'h480, 8'h39);
    wr(12'h480, 8'h30);
    @(posedge sys_clk) sr <= 1'b0;
    errs(0, 2);
    cnt(0, 0, 8'h00);
    cnt(0, 2, 8'h03);
    @(posedge sys_clk) sr <= 1'b1;
    wr(12'h480, 8'h3F);
    wr(12'h480, 8'h38);
    wr(12'h477, 8'h08);
    rd("ctrl", 12'h477, 8'h08);
    wr(12'h47D, 8'h02);
    @(posedge sys_clk) sr <= 1'b0;
    errs(0, 1);
    errs(1, 3);
    cnt(0, 1, 8'h00);
    cnt(0, 0, 8'h01);
    chk("sync", 8'h00, {7'h00, sync_o});
    wrap_up();
  end
endmodule
